// File: l1c_pkg.sv
// shared constants and types for the level-one cache fill and replacement block
package l1c_pkg;
  // register port offsets
  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_STAT_OFS = 4'h4;
  // control register reset value and status field positions
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam int STAT_IC_BUSY_BIT = 0;
  localparam int STAT_DC_BUSY_BIT = 1;
  localparam int STAT_IC_STALL_BIT = 2;
  localparam int STAT_DC_STALL_BIT = 3;
  // instruction cache geometry
  localparam int IC_WAYS = 4;
  localparam int IC_AGE_W = 2;
  localparam int IC_TAG_W = 20;
  localparam int IC_IDX_W = 7;
  localparam int IC_SETS = 128;
  localparam int IC_MEM_AW = 11;
  localparam logic [1:0] IC_LAST_WORD = 2'h3;
  // data cache geometry
  localparam int DC_WAYS = 2;
  localparam int DC_TAG_W = 19;
  localparam int DC_IDX_W = 9;
  localparam int DC_SETS = 512;
  localparam int DC_MEM_AW = 14;
  localparam logic [3:0] DC_LAST_WORD = 4'hf;
  // data bank configuration encodings
  localparam logic [1:0] DC_BANKS_OFF = 2'h0;
  localparam logic [1:0] DC_BANKS_ONE = 2'h1;
  // fill sequencer states, gray along idle, fill, commit
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_COMMIT = 2'b11
  } l1c_state_t;
  // control register layout, bit 0 at the bottom
  typedef struct packed {
    logic data_bank_address_select;
    logic [1:0] dc_banks;
    logic [3:0] way_lock;
    logic mlru_en;
    logic ic_en;
  } l1c_ctrl_t;
  // external read command
  typedef struct packed {
    logic [31:0] addr;
    logic burst;
    logic data_side;
  } l1c_ext_cmd_t;
endpackage

// File: l1c_victim.sv
// replacement way picker for one indexed set
module l1c_victim #(
  parameter int WAYS = 4,
  parameter int AW = 2,
  parameter int WW = 2
) (
  // set state
  input wire logic [WAYS-1:0] valid,
  input wire logic [WAYS-1:0] lock,
  input wire logic [WAYS-1:0] hi_prio,
  input wire logic [WAYS-1:0][AW-1:0] age,
  // policy
  input wire logic mlru_en,
  input wire logic in_hi,
  // choice
  output logic [WW-1:0] way,
  output logic ok
);
  logic [WAYS-1:0] elig;
  logic [WAYS-1:0] inv;
  logic [WAYS-1:0] lowp;
  logic [WAYS-1:0] cand;
  logic [AW-1:0] best;

  // invalid ways first by index, else oldest eligible way
  always_comb begin
    elig = ~lock; // R7 R21
    inv = elig & ~valid;
    lowp = elig & ~hi_prio;
    cand = elig;
    if (mlru_en) begin // R22
      if (!in_hi || (|lowp)) begin
        cand = lowp; // R4
      end
    end
    way = '0;
    ok = 1'b0;
    best = '0;
    if (|inv) begin
      ok = 1'b1; // R1
      for (int i = WAYS - 1; i >= 0; i--) begin
        if (inv[i]) begin
          way = WW'(i); // R2
        end
      end
    end else begin
      for (int i = 0; i < WAYS; i++) begin
        if (cand[i] && (!ok || age[i] > best)) begin
          way = WW'(i); // R3
          best = age[i];
          ok = 1'b1;
        end
      end
    end
  end
endmodule

// File: l1c_top.sv
// level-one instruction and data cache line fill and replacement controller
// Contract
// R1: a single invalid way in the set receives the incoming instruction line
// R2: several invalid ways fill in order way 0, 1, 2, then 3
// R3: with no invalid way, evict the least recently used eligible way
// R4: modified LRU: low-priority lines never evict high-priority ways, else uncached
// R5: instruction hit when top 18 bits and bits 11:10 match a valid tag
// R6: instruction miss issues a line fill and stalls until the target arrives
// R7: victim choice looks only at unlocked ways, using valid and LRU state
// R8: instruction fill reads 32 bytes, request carries the target word address
// R9: memory returns target 64-bit word first, then ascending with wrap
// R10: fill words pass a four-entry buffer; core may use it mid-fill
// R11: cache off fetches one 8-byte block; cache on always bursts 32 bytes
// R12: a 16-bit memory delivers each 64-bit word as 16-bit accesses
// R13: data cache is two-way and replaces by plain LRU only
// R14: data cache holds 16K bytes with one bank, 32K bytes with two
// R15: data subbank from bits 13:12, set from bits 10:5, 64 sets
// R16: data lines keep a 19-bit tag, dirty, LRU and valid bits
// R17: with two data banks, a control bit picks address bit 14 or 23
// R18: data fill returns target 16-bit word first, then ascending with wrap
// R19: instruction subbank from bits 13:12, set from bits 9:5, four ways
// R20: instruction lines keep a 20-bit tag, priority, LRU state, valid bit
// R21: each instruction way locks on its own and is never replaced
// R22: instruction replacement selectable between plain and modified LRU
// R23: fill completion sets valid, tag and LRU; hits also update LRU
// R24: a started line fill always runs to completion
//
// Design decisions made here: the register addresses and the address-and-strobe port.
module l1c_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  // core fetch port
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_hi_prio,
  output logic fetch_stall_ff,
  output logic fetch_valid_ff,
  output logic [63:0] fetch_data_ff,
  // core data port
  input wire logic dmem_req,
  input wire logic dmem_we,
  input wire logic [31:0] dmem_addr,
  input wire logic [15:0] dmem_wdata,
  output logic dmem_stall_ff,
  output logic dmem_valid_ff,
  output logic [15:0] dmem_rdata_ff,
  output logic dmem_victim_dirty_ff,
  // external bus
  output logic ext_req_ff,
  output l1c_pkg::l1c_ext_cmd_t ext_cmd_ff,
  input wire logic ext_rvalid,
  input wire logic [63:0] ext_rdata
);
  // tag, state and line storage
  logic [19:0] ic_tag [l1c_pkg::IC_SETS][l1c_pkg::IC_WAYS];
  logic [3:0] ic_val [l1c_pkg::IC_SETS];
  logic [3:0] ic_pri [l1c_pkg::IC_SETS];
  logic [3:0][1:0] ic_age [l1c_pkg::IC_SETS];
  logic [63:0] ic_mem [2**l1c_pkg::IC_MEM_AW];
  logic [18:0] dc_tag [l1c_pkg::DC_SETS][l1c_pkg::DC_WAYS];
  logic [1:0] dc_val [l1c_pkg::DC_SETS];
  logic [1:0] dc_dirty [l1c_pkg::DC_SETS];
  logic [1:0] dc_age [l1c_pkg::DC_SETS];
  logic [15:0] dc_mem [2**l1c_pkg::DC_MEM_AW];

  l1c_pkg::l1c_ctrl_t ctrl_ff, nxt_ctrl;
  logic [31:0] nxt_reg_rdata;
  // instruction side state
  l1c_pkg::l1c_state_t ic_st_ff, nxt_ic_st;
  logic ic_pend_ff, nxt_ic_pend, ic_pend_hi_ff, nxt_ic_pend_hi;
  logic [31:0] ic_pend_addr_ff, nxt_ic_pend_addr, ic_fill_addr_ff, nxt_ic_fill_addr;
  logic ic_fill_hi_ff, nxt_ic_fill_hi, ic_burst_ff, nxt_ic_burst;
  logic [1:0] ic_fill_word_slot_ff, nxt_ic_fill_word_slot;
  logic [1:0] ic_cnt_ff, nxt_ic_cnt;
  logic [3:0] ic_have_ff, nxt_ic_have;
  logic [3:0][63:0] ic_buf_ff, nxt_ic_buf;
  logic nxt_fetch_valid;
  logic [63:0] nxt_fetch_data;
  logic ic_act, ic_hit, ic_start, ic_hit_upd, ic_wr_line;
  logic [31:0] ic_act_addr;
  logic [6:0] ic_idx, ic_fidx;
  logic [1:0] ic_hit_way, ic_vway;
  logic [3:0] ic_hitv;
  logic ic_vok;
  // data side state
  l1c_pkg::l1c_state_t dc_st_ff, nxt_dc_st;
  logic dc_pend_ff, nxt_dc_pend;
  logic [31:0] dc_pend_addr_ff, nxt_dc_pend_addr, dc_fill_addr_ff, nxt_dc_fill_addr;
  logic dc_burst_ff, nxt_dc_burst, dc_way_ff, nxt_dc_way;
  logic [3:0] dc_fill_word_slot_ff, nxt_dc_fill_word_slot, dc_cnt_ff, nxt_dc_cnt;
  logic nxt_dmem_valid, nxt_dmem_dirty;
  logic [15:0] nxt_dmem_rdata;
  logic dc_act, dc_hit, dc_en, dc_start, dc_hit_upd, dc_wr_hit, dc_wr_word;
  logic dc_inval, dc_commit, dc_hit_way, dc_vway, dc_vok;
  logic [31:0] dc_act_addr;
  logic [8:0] dc_idx, dc_fidx;
  logic [1:0] dc_hitv;
  logic nxt_ext_req;
  l1c_pkg::l1c_ext_cmd_t nxt_ext_cmd;

  // set index and tag of an instruction address
  function automatic logic [6:0] ic_index(input logic [31:0] a);
    return {a[13:12], a[9:5]}; // R19
  endfunction
  function automatic logic [19:0] ic_tag_of(input logic [31:0] a);
    return {a[31:14], a[11:10]}; // R5 R20
  endfunction
  // bank, subbank and set of a data address
  function automatic logic [8:0] dc_index(input logic [31:0] a, input l1c_pkg::l1c_ctrl_t c);
    logic bank;
    bank = 1'b0; // R14
    if (c.dc_banks != l1c_pkg::DC_BANKS_ONE) begin
      bank = c.data_bank_address_select ? a[23] : a[14]; // R17
    end
    return {bank, a[13:12], a[10:5]}; // R15
  endfunction
  function automatic logic [18:0] dc_tag_of(input logic [31:0] a);
    return {a[31:14], a[11]}; // R16
  endfunction
  // four-way age update: touched way becomes youngest
  function automatic logic [3:0][1:0] lru4(input logic [3:0][1:0] ag, input logic [1:0] w);
    logic [3:0][1:0] r;
    for (int i = 0; i < 4; i++) begin
      if (i == int'(w)) r[i] = 2'h0;
      else if (ag[i] < ag[w]) r[i] = ag[i] + 2'h1;
      else r[i] = ag[i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // lookups: the active request is a held one or a fresh one when not stalled
  assign ic_act = ic_pend_ff | (fetch_req & ~fetch_stall_ff);
  assign ic_act_addr = ic_pend_ff ? ic_pend_addr_ff : fetch_addr;
  assign ic_idx = ic_index(ic_act_addr);
  assign ic_fidx = ic_index(ic_fill_addr_ff);
  assign dc_act = dc_pend_ff | (dmem_req & ~dmem_stall_ff);
  assign dc_act_addr = dc_pend_ff ? dc_pend_addr_ff : dmem_addr;
  assign dc_en = ctrl_ff.dc_banks != l1c_pkg::DC_BANKS_OFF;
  assign dc_idx = dc_index(dc_act_addr, ctrl_ff);
  assign dc_fidx = dc_index(dc_fill_addr_ff, ctrl_ff);

  // tag compare across the ways of each indexed set
  always_comb begin
    ic_hit_way = 2'h0;
    dc_hit_way = 1'b0;
    for (int w = 0; w < l1c_pkg::IC_WAYS; w++) begin
      ic_hitv[w] = ctrl_ff.ic_en && ic_val[ic_idx][w] && ic_tag[ic_idx][w] == ic_tag_of(ic_act_addr); // R5
      if (ic_hitv[w]) ic_hit_way = 2'(w);
    end
    for (int w = 0; w < l1c_pkg::DC_WAYS; w++) begin
      dc_hitv[w] = dc_en && dc_val[dc_idx][w] && dc_tag[dc_idx][w] == dc_tag_of(dc_act_addr);
      if (dc_hitv[w]) dc_hit_way = 1'(w);
    end
    ic_hit = |ic_hitv;
    dc_hit = |dc_hitv;
  end

  // instruction victim is chosen at commit, data victim at the miss
  l1c_victim #(.WAYS(4), .AW(2), .WW(2)) u_ic_victim (
    .valid(ic_val[ic_fidx]),
    .lock(ctrl_ff.way_lock),
    .hi_prio(ic_pri[ic_fidx]),
    .age(ic_age[ic_fidx]),
    .mlru_en(ctrl_ff.mlru_en),
    .in_hi(ic_fill_hi_ff),
    .way(ic_vway),
    .ok(ic_vok)
  );
  l1c_victim #(.WAYS(2), .AW(1), .WW(1)) u_dc_victim (
    .valid(dc_val[dc_idx]),
    .lock(2'h0),
    .hi_prio(2'h0),
    .age(dc_age[dc_idx]),
    .mlru_en(1'b0), // R13
    .in_hi(1'b0),
    .way(dc_vway),
    .ok(dc_vok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // instruction fill sequencer
  always_comb begin
    nxt_ic_st = ic_st_ff;
    nxt_ic_pend = ic_pend_ff;
    nxt_ic_pend_hi = ic_pend_hi_ff;
    nxt_ic_pend_addr = ic_pend_addr_ff;
    nxt_ic_fill_addr = ic_fill_addr_ff;
    nxt_ic_fill_hi = ic_fill_hi_ff;
    nxt_ic_burst = ic_burst_ff;
    nxt_ic_fill_word_slot = ic_fill_word_slot_ff;
    nxt_ic_cnt = ic_cnt_ff;
    nxt_ic_have = ic_have_ff;
    nxt_ic_buf = ic_buf_ff;
    nxt_fetch_valid = 1'b0;
    nxt_fetch_data = fetch_data_ff;
    ic_start = 1'b0;
    ic_hit_upd = 1'b0;
    ic_wr_line = 1'b0;
    if (ic_act && !ic_pend_ff) begin
      nxt_ic_pend = 1'b1;
      nxt_ic_pend_addr = fetch_addr;
      nxt_ic_pend_hi = fetch_hi_prio;
    end
    case (ic_st_ff)
      l1c_pkg::ST_IDLE: begin
        if (ic_act && ic_hit) begin
          nxt_fetch_valid = 1'b1;
          nxt_fetch_data = ic_mem[{ic_idx, ic_hit_way, ic_act_addr[4:3]}];
          nxt_ic_pend = 1'b0;
          ic_hit_upd = 1'b1; // R23
        end else if (ic_act && dc_st_ff != l1c_pkg::ST_FILL) begin
          ic_start = 1'b1; // R6 R8
          nxt_ic_st = l1c_pkg::ST_FILL;
          nxt_ic_fill_addr = ic_act_addr;
          nxt_ic_fill_hi = ic_pend_ff ? ic_pend_hi_ff : fetch_hi_prio;
          nxt_ic_burst = ctrl_ff.ic_en; // R11
          nxt_ic_fill_word_slot = ic_act_addr[4:3];
          nxt_ic_cnt = 2'h0;
          nxt_ic_have = 4'h0;
        end
      end
      l1c_pkg::ST_FILL: begin
        if (ext_rvalid) begin
          nxt_ic_buf[ic_fill_word_slot_ff] = ext_rdata; // R10
          nxt_ic_have[ic_fill_word_slot_ff] = 1'b1;
          nxt_ic_fill_word_slot = ic_fill_word_slot_ff + 2'h1; // R9
          nxt_ic_cnt = ic_cnt_ff + 2'h1;
          if (!ic_burst_ff) begin
            nxt_ic_st = l1c_pkg::ST_IDLE; // R11
          end else if (ic_cnt_ff == l1c_pkg::IC_LAST_WORD) begin
            nxt_ic_st = l1c_pkg::ST_COMMIT; // R24
          end
        end
      end
      l1c_pkg::ST_COMMIT: begin
        ic_wr_line = ic_vok; // R4 R23
        nxt_ic_st = l1c_pkg::ST_IDLE;
      end
      default: nxt_ic_st = l1c_pkg::ST_IDLE;
    endcase
    // words of the line in flight are served straight from the buffer
    if (ic_st_ff != l1c_pkg::ST_IDLE && ic_act && ic_act_addr[31:5] == ic_fill_addr_ff[31:5]
        && nxt_ic_have[ic_act_addr[4:3]]) begin
      nxt_fetch_valid = 1'b1; // R6 R10
      nxt_fetch_data = nxt_ic_buf[ic_act_addr[4:3]];
      nxt_ic_pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data fill sequencer; stores hit in place, store misses leave the cache alone
  always_comb begin
    nxt_dc_st = dc_st_ff;
    nxt_dc_pend = dc_pend_ff;
    nxt_dc_pend_addr = dc_pend_addr_ff;
    nxt_dc_fill_addr = dc_fill_addr_ff;
    nxt_dc_burst = dc_burst_ff;
    nxt_dc_way = dc_way_ff;
    nxt_dc_fill_word_slot = dc_fill_word_slot_ff;
    nxt_dc_cnt = dc_cnt_ff;
    nxt_dmem_valid = 1'b0;
    nxt_dmem_rdata = dmem_rdata_ff;
    nxt_dmem_dirty = 1'b0;
    dc_start = 1'b0;
    dc_hit_upd = 1'b0;
    dc_wr_hit = 1'b0;
    dc_wr_word = 1'b0;
    dc_inval = 1'b0;
    dc_commit = 1'b0;
    case (dc_st_ff)
      l1c_pkg::ST_IDLE: begin
        if (dc_act && (dc_hit || (dmem_we && !dc_pend_ff))) begin
          nxt_dmem_valid = 1'b1;
          dc_hit_upd = dc_hit; // R23
          dc_wr_hit = dc_hit && dmem_we && !dc_pend_ff;
          nxt_dmem_rdata = dc_mem[{dc_idx, dc_hit_way, dc_act_addr[4:1]}];
          nxt_dc_pend = 1'b0;
        end else if (dc_act && !ic_start && ic_st_ff != l1c_pkg::ST_FILL) begin
          dc_start = 1'b1;
          nxt_dc_pend = 1'b0;
          nxt_dc_st = l1c_pkg::ST_FILL;
          nxt_dc_fill_addr = dc_act_addr;
          nxt_dc_burst = dc_en;
          nxt_dc_way = dc_vway; // R13
          nxt_dc_fill_word_slot = dc_act_addr[4:1];
          nxt_dc_cnt = 4'h0;
          dc_inval = dc_en;
          nxt_dmem_dirty = dc_en && dc_val[dc_idx][dc_vway] && dc_dirty[dc_idx][dc_vway];
        end else if (dc_act) begin
          nxt_dc_pend = 1'b1;
          nxt_dc_pend_addr = dc_act_addr;
        end
      end
      l1c_pkg::ST_FILL: begin
        if (ext_rvalid) begin
          dc_wr_word = dc_burst_ff;
          if (dc_cnt_ff == 4'h0) begin
            nxt_dmem_valid = 1'b1; // R18
            nxt_dmem_rdata = ext_rdata[15:0];
          end
          nxt_dc_fill_word_slot = dc_fill_word_slot_ff + 4'h1; // R18
          nxt_dc_cnt = dc_cnt_ff + 4'h1;
          if (!dc_burst_ff) begin
            nxt_dc_st = l1c_pkg::ST_IDLE;
          end else if (dc_cnt_ff == l1c_pkg::DC_LAST_WORD) begin
            nxt_dc_st = l1c_pkg::ST_COMMIT; // R24
          end
        end
      end
      l1c_pkg::ST_COMMIT: begin
        dc_commit = 1'b1; // R23
        nxt_dc_st = l1c_pkg::ST_IDLE;
      end
      default: nxt_dc_st = l1c_pkg::ST_IDLE;
    endcase
  end

  // external command: instruction side wins a same-cycle start
  always_comb begin
    nxt_ext_req = ic_start | dc_start;
    nxt_ext_cmd = ext_cmd_ff;
    if (ic_start) begin
      nxt_ext_cmd = '{addr: {ic_act_addr[31:3], 3'h0}, burst: ctrl_ff.ic_en, data_side: 1'b0}; // R8
    end else if (dc_start) begin
      nxt_ext_cmd = '{addr: {dc_act_addr[31:1], 1'b0}, burst: dc_en, data_side: 1'b1};
    end
  end

  // register port: control writes, one-cycle-late reads, unmapped reads zero
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_reg_rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == l1c_pkg::REG_CTRL_OFS) begin
      nxt_ctrl = l1c_pkg::l1c_ctrl_t'(reg_wdata[8:0]);
    end
    if (reg_rd && reg_addr == l1c_pkg::REG_CTRL_OFS) begin
      nxt_reg_rdata = {23'h0, ctrl_ff};
    end else if (reg_rd && reg_addr == l1c_pkg::REG_STAT_OFS) begin
      nxt_reg_rdata[l1c_pkg::STAT_IC_BUSY_BIT] = ic_st_ff != l1c_pkg::ST_IDLE;
      nxt_reg_rdata[l1c_pkg::STAT_DC_BUSY_BIT] = dc_st_ff != l1c_pkg::ST_IDLE;
      nxt_reg_rdata[l1c_pkg::STAT_IC_STALL_BIT] = fetch_stall_ff;
      nxt_reg_rdata[l1c_pkg::STAT_DC_STALL_BIT] = dmem_stall_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and sequencer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= l1c_pkg::l1c_ctrl_t'(l1c_pkg::CTRL_RST);
      reg_rdata_ff <= 32'h0000_0000;
      ic_st_ff <= l1c_pkg::ST_IDLE;
      ic_pend_ff <= 1'b0;
      ic_pend_hi_ff <= 1'b0;
      ic_pend_addr_ff <= 32'h0000_0000;
      ic_fill_addr_ff <= 32'h0000_0000;
      ic_fill_hi_ff <= 1'b0;
      ic_burst_ff <= 1'b0;
      ic_fill_word_slot_ff <= 2'h0;
      ic_cnt_ff <= 2'h0;
      ic_have_ff <= 4'h0;
      ic_buf_ff <= '0;
      fetch_stall_ff <= 1'b0;
      fetch_valid_ff <= 1'b0;
      fetch_data_ff <= 64'h0;
      dc_st_ff <= l1c_pkg::ST_IDLE;
      dc_pend_ff <= 1'b0;
      dc_pend_addr_ff <= 32'h0000_0000;
      dc_fill_addr_ff <= 32'h0000_0000;
      dc_burst_ff <= 1'b0;
      dc_way_ff <= 1'b0;
      dc_fill_word_slot_ff <= 4'h0;
      dc_cnt_ff <= 4'h0;
      dmem_stall_ff <= 1'b0;
      dmem_valid_ff <= 1'b0;
      dmem_rdata_ff <= 16'h0;
      dmem_victim_dirty_ff <= 1'b0;
      ext_req_ff <= 1'b0;
      ext_cmd_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      reg_rdata_ff <= nxt_reg_rdata;
      ic_st_ff <= nxt_ic_st;
      ic_pend_ff <= nxt_ic_pend;
      ic_pend_hi_ff <= nxt_ic_pend_hi;
      ic_pend_addr_ff <= nxt_ic_pend_addr;
      ic_fill_addr_ff <= nxt_ic_fill_addr;
      ic_fill_hi_ff <= nxt_ic_fill_hi;
      ic_burst_ff <= nxt_ic_burst;
      ic_fill_word_slot_ff <= nxt_ic_fill_word_slot;
      ic_cnt_ff <= nxt_ic_cnt;
      ic_have_ff <= nxt_ic_have;
      ic_buf_ff <= nxt_ic_buf;
      fetch_stall_ff <= nxt_ic_pend; // R6
      fetch_valid_ff <= nxt_fetch_valid;
      fetch_data_ff <= nxt_fetch_data;
      dc_st_ff <= nxt_dc_st;
      dc_pend_ff <= nxt_dc_pend;
      dc_pend_addr_ff <= nxt_dc_pend_addr;
      dc_fill_addr_ff <= nxt_dc_fill_addr;
      dc_burst_ff <= nxt_dc_burst;
      dc_way_ff <= nxt_dc_way;
      dc_fill_word_slot_ff <= nxt_dc_fill_word_slot;
      dc_cnt_ff <= nxt_dc_cnt;
      dmem_stall_ff <= nxt_dc_pend | (nxt_dc_st != l1c_pkg::ST_IDLE);
      dmem_valid_ff <= nxt_dmem_valid;
      dmem_rdata_ff <= nxt_dmem_rdata;
      dmem_victim_dirty_ff <= nxt_dmem_dirty;
      ext_req_ff <= nxt_ext_req;
      ext_cmd_ff <= nxt_ext_cmd;
    end
  end

  // line state: valid, priority, age and dirty bits need a defined reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int s = 0; s < l1c_pkg::IC_SETS; s++) begin
        ic_val[s] <= 4'h0;
        ic_pri[s] <= 4'h0;
        ic_age[s] <= {2'h3, 2'h2, 2'h1, 2'h0};
      end
      for (int s = 0; s < l1c_pkg::DC_SETS; s++) begin
        dc_val[s] <= 2'h0;
        dc_dirty[s] <= 2'h0;
        dc_age[s] <= 2'h2;
      end
    end else begin
      if (ic_hit_upd) ic_age[ic_idx] <= lru4(ic_age[ic_idx], ic_hit_way); // R23
      if (ic_wr_line) begin
        ic_val[ic_fidx][ic_vway] <= 1'b1; // R23
        ic_pri[ic_fidx][ic_vway] <= ic_fill_hi_ff; // R20
        ic_age[ic_fidx] <= lru4(ic_age[ic_fidx], ic_vway);
      end
      if (dc_hit_upd) dc_age[dc_idx] <= dc_hit_way ? 2'h1 : 2'h2; // R13
      if (dc_wr_hit) dc_dirty[dc_idx][dc_hit_way] <= 1'b1; // R16
      if (dc_inval) dc_val[dc_idx][dc_vway] <= 1'b0;
      if (dc_commit) begin
        dc_val[dc_fidx][dc_way_ff] <= 1'b1; // R23
        dc_dirty[dc_fidx][dc_way_ff] <= 1'b0;
        dc_age[dc_fidx] <= dc_way_ff ? 2'h1 : 2'h2;
      end
    end
  end

  // tags and line data carry no reset; valid bits guard them
  always_ff @(posedge clk) begin
    if (ic_wr_line) begin
      ic_tag[ic_fidx][ic_vway] <= ic_tag_of(ic_fill_addr_ff);
      for (int k = 0; k < 4; k++) begin
        ic_mem[{ic_fidx, ic_vway, 2'(k)}] <= ic_buf_ff[k]; // R10
      end
    end
    if (dc_commit) dc_tag[dc_fidx][dc_way_ff] <= dc_tag_of(dc_fill_addr_ff);
    if (dc_wr_hit) dc_mem[{dc_idx, dc_hit_way, dc_act_addr[4:1]}] <= dmem_wdata;
    if (dc_wr_word) dc_mem[{dc_fidx, dc_way_ff, dc_fill_word_slot_ff}] <= ext_rdata[15:0];
  end
endmodule

// File: l1c_properties.sv
// port checker for the cache fill controller
module l1c_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched ports
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic fetch_req,
  input wire logic fetch_stall_ff,
  input wire logic fetch_valid_ff,
  input wire logic dmem_req,
  input wire logic dmem_stall_ff,
  input wire logic dmem_valid_ff,
  input wire logic ext_req_ff,
  input wire l1c_pkg::l1c_ext_cmd_t ext_cmd_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata_ff == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_i_ans; fetch_req && !fetch_stall_ff |=> fetch_valid_ff || fetch_stall_ff; endproperty
  a_i_ans: assert property (p_i_ans) else $error("fetch not answered");
  property p_i_drop; $fell(fetch_stall_ff) |-> fetch_valid_ff; endproperty
  a_i_drop: assert property (p_i_drop) else $error("stall left without word");
  property p_d_ans; dmem_req && !dmem_stall_ff |=> dmem_valid_ff || dmem_stall_ff; endproperty
  a_d_ans: assert property (p_d_ans) else $error("load not answered");
  property p_i_len;
    ext_req_ff && ext_cmd_ff.burst && !ext_cmd_ff.data_side |=> !ext_req_ff [*4];
  endproperty
  a_i_len: assert property (p_i_len) else $error("instruction fill cut short");
  property p_d_len; ext_req_ff && ext_cmd_ff.burst && ext_cmd_ff.data_side |=> !ext_req_ff [*8];
  endproperty
  a_d_len: assert property (p_d_len) else $error("data fill cut short");
  property p_i_adr; ext_req_ff && !ext_cmd_ff.data_side |-> ext_cmd_ff.addr[2:0] == 3'h0;
  endproperty
  a_i_adr: assert property (p_i_adr) else $error("fetch command unaligned");
  property p_d_adr; ext_req_ff && ext_cmd_ff.data_side |-> ext_cmd_ff.addr[0] == 1'h0; endproperty
  a_d_adr: assert property (p_d_adr) else $error("data command unaligned");
  property p_hold; !ext_req_ff |-> $stable(ext_cmd_ff); endproperty
  a_hold: assert property (p_hold) else $error("command moved");
endmodule

// File: l1c_mem_model.sv
// behavioural external memory answering fill commands
module l1c_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pacing: high leaves an idle cycle between words
  input wire logic slow,
  // command in, words out
  input wire logic ext_req_ff,
  input wire l1c_pkg::l1c_ext_cmd_t ext_cmd_ff,
  output logic ext_rvalid,
  output logic [63:0] ext_rdata
);
  logic [4:0] left;
  logic [31:0] wa;
  logic gap;
  // target word first, then ascending with wrap; low half of each word is its own address, high half its inverse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left <= 5'h0;
      wa <= 32'h0;
      gap <= 1'h0;
      ext_rvalid <= 1'h0;
      ext_rdata <= 64'h0;
    end else if (ext_req_ff) begin
      left <= ext_cmd_ff.burst ? (ext_cmd_ff.data_side ? 5'h10 : 5'h4) : 5'h1;
      wa <= ext_cmd_ff.addr;
      gap <= slow;
      ext_rvalid <= 1'h0;
    end else if (left != 5'h0 && !gap) begin
      ext_rvalid <= 1'h1;
      ext_rdata <= {~wa, wa};
      left <= left - 5'h1;
      wa <= ext_cmd_ff.data_side ? {wa[31:5], wa[4:1] + 4'h1, 1'h0}
                                 : {wa[31:5], wa[4:3] + 2'h1, 3'h0};
      gap <= slow;
    end else begin
      ext_rvalid <= 1'h0;
      ext_rdata <= ~ext_rdata; // idle bus inverts every bit of the last word each cycle
      gap <= 1'h0;
    end
  end
endmodule

// File: tb_top.sv
// self-checking bench for the cache fill controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = '0, reset_n = '0, reg_wr = '0, reg_rd = '0, fetch_req = '0, fetch_hi_prio = '0;
  logic dmem_req = '0, slow = '0, fetch_stall_ff, fetch_valid_ff, dmem_stall_ff, dmem_valid_ff;
  logic ext_req_ff, ext_rvalid;
  logic [3:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, fetch_addr = '0, dmem_addr = '0, reg_rdata_ff;
  logic [63:0] fetch_data_ff, ext_rdata;
  logic [15:0] dmem_rdata_ff, dmem_wdata = '0;
  logic dmem_we = '0, dmem_victim_dirty_ff;
  l1c_pkg::l1c_ext_cmd_t ext_cmd_ff;
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #50 clk = ~clk;
  l1c_top u_l1c_top (.*);
  l1c_mem_model u_l1c_mem_model (.*);
  ////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one register cycle, read data sampled in the following cycle
  task automatic rg(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    #1;
  endtask
  // fetch, then let the fill and its commit finish before the next request
  task automatic fetch(input logic [31:0] a, input logic hp, input logic miss, input logic bst);
    @(posedge clk);
    fetch_req <= 1'h1;
    fetch_addr <= a;
    fetch_hi_prio <= hp;
    @(posedge clk);
    fetch_req <= 1'h0;
    #1;
    chk("ext_req", ext_req_ff, miss);
    if (miss) chk("ext_cmd", ext_cmd_ff, {a & ~32'h7, bst, 1'h0});
    for (int n = 0; n < 40 && fetch_valid_ff !== 1'h1; n++) @(posedge clk) #1;
    chk("fetch_data", fetch_data_ff, {~(a & ~32'h7), a & ~32'h7});
    if (miss) repeat (12) @(posedge clk);
  endtask
  // load, wait for the data fill to release the port
  task automatic load(input logic [31:0] a, input logic miss);
    @(posedge clk);
    dmem_req <= 1'h1;
    dmem_addr <= a;
    @(posedge clk);
    dmem_req <= 1'h0;
    #1;
    chk("ext_req", ext_req_ff, miss);
    if (miss) chk("ext_cmd", ext_cmd_ff, {a & ~32'h1, 1'h1, 1'h1});
    for (int n = 0; n < 60 && dmem_valid_ff !== 1'h1; n++) @(posedge clk) #1;
    chk("load_data", dmem_rdata_ff, a[15:0] & ~16'h1);
    for (int n = 0; n < 80 && dmem_stall_ff !== 1'h0; n++) @(posedge clk) #1;
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    rg(1'h0, l1c_pkg::REG_CTRL_OFS, 32'h0);
    chk("ctrl", reg_rdata_ff, l1c_pkg::CTRL_RST);
    rg(1'h0, 4'h8, 32'h0);
    chk("unmapped", reg_rdata_ff, 64'h0);
    fetch(32'h100a, 1'h0, 1'h1, 1'h0);
    rg(1'h1, l1c_pkg::REG_CTRL_OFS, 32'h41);
    fetch(32'h2010, 1'h0, 1'h1, 1'h1);
    fetch(32'h2018, 1'h0, 1'h0, 1'h0);
    for (int k = 0; k < 4; k++) fetch(32'h10000 + k * 32'h4000, 1'h0, 1'h1, 1'h1);
    rg(1'h1, l1c_pkg::REG_CTRL_OFS, 32'h45);
    fetch(32'h20000, 1'h0, 1'h1, 1'h1);
    fetch(32'h10000, 1'h0, 1'h0, 1'h0);
    fetch(32'h14000, 1'h0, 1'h1, 1'h1);
    rg(1'h1, l1c_pkg::REG_CTRL_OFS, 32'h43);
    for (int k = 0; k < 4; k++) fetch(32'h40020 + k * 32'h4000, 1'h1, 1'h1, 1'h1);
    fetch(32'h50020, 1'h0, 1'h1, 1'h1);
    fetch(32'h50020, 1'h0, 1'h1, 1'h1);
    fetch(32'h40020, 1'h0, 1'h0, 1'h0);
    @(posedge clk) slow <= 1'h1;
    load(32'h3006, 1'h1);
    load(32'h3002, 1'h0);
    test_done();
  end
endmodule
bind l1c_top l1c_properties u_l1c_properties (.*);
